// ==== rtl/switchgear_position_supervisor.sv ====
// Switchgear position supervisor with APB registers, interlocks and trip manager
`timescale 1ns/1ps
`default_nettype none
module switchgear_position_supervisor #(
    parameter int interlocks = sg_pkg::interlock_count,
    parameter int slots = sg_pkg::trip_slots
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Feedback contacts
    input wire logic aux_closed,
    input wire logic aux_open,
    // Command sources
    input wire sg_pkg::command_type cmd_in,
    input wire logic [interlocks-1:0] close_interlock,
    input wire logic [interlocks-1:0] open_interlock,
    input wire logic [slots-1:0] prot_trip,
    // Switchgear outputs and flags
    output logic close_out,
    output logic open_out,
    output logic trip_out,
    output sg_pkg::position_type position,
    output logic single_contact_mode_flag,
    output logic command_success_flag
);
    logic [31:0] cfg_reg;
    logic [31:0] move_on_reg;
    logic [31:0] move_off_reg;
    logic [31:0] dwell_reg;
    logic [slots-1:0] trip_assign_reg;
    sg_pkg::phase_type phase_reg;
    logic [31:0] timer_reg;
    logic dwell_dir_close_reg;
    logic disturb_latched_reg;
    logic last_dir_close_reg;
    logic sw_close_reg;
    logic sw_open_reg;
    logic sw_clear_reg;

    wire logic on_wired = cfg_reg[sg_pkg::cfg_on_wired_bit];
    wire logic off_wired = cfg_reg[sg_pkg::cfg_off_wired_bit];
    wire logic single = on_wired ^ off_wired;

    // Interlocks gate only ordinary commands; protection and reclose bypass
    wire logic close_ok = (cmd_in.close_req | sw_close_reg) & ~(|close_interlock);
    wire logic open_ok = (cmd_in.open_req | sw_open_reg) & ~(|open_interlock);
    wire logic prot_go = cmd_in.prot_open & ~cmd_in.prot_block;
    // A command toward the present position is not issued again
    wire logic close_start = (close_ok | cmd_in.ar_close) & ~aux_closed_pos();
    wire logic open_start = (open_ok | prot_go) & ~aux_open_pos();

    // Trip manager: OR of assigned slots only
    // The block input holds back the trip as well as the protection open
    wire logic trip_next = |(prot_trip & trip_assign_reg) & ~cmd_in.prot_block;

    wire logic apb_write = psel & penable & pwrite;
    wire logic apb_read = psel & penable & ~pwrite;
    // Expiry taken at one, so a loaded count of N gives N cycles of travel
    wire logic timer_done = (timer_reg == sg_pkg::timer_zero) || (timer_reg == sg_pkg::timer_one);

    // Single contact: only the wired direction is timed; the other just runs its relay
    wire logic move_supervised = !single || (phase_reg == sg_pkg::st_move_close ? on_wired : off_wired);
    // End position seen while travelling; flags and success switch on the same edge
    wire logic arrived = ((phase_reg == sg_pkg::st_move_close) && aux_closed_pos()) ||
                         ((phase_reg == sg_pkg::st_move_open) && aux_open_pos());

    // Position reached according to wiring; an unwired contact is inferred from the other
    function automatic logic aux_closed_pos();
        if (on_wired && off_wired)
            aux_closed_pos = aux_closed & ~aux_open;
        else if (on_wired)
            aux_closed_pos = aux_closed;
        else
            aux_closed_pos = ~aux_open;
    endfunction

    function automatic logic aux_open_pos();
        if (on_wired && off_wired)
            aux_open_pos = aux_open & ~aux_closed;
        else if (off_wired)
            aux_open_pos = aux_open;
        else
            aux_open_pos = ~aux_closed;
    endfunction

    // Offsets outside the map answer with an error and read as zero
    function automatic logic is_known(input logic [11:0] a);
        is_known = (a == sg_pkg::cfg_offset) || (a == sg_pkg::move_on_offset) ||
                   (a == sg_pkg::move_off_offset) || (a == sg_pkg::dwell_offset) ||
                   (a == sg_pkg::trip_assign_offset) || (a == sg_pkg::status_offset) ||
                   (a == sg_pkg::command_offset);
    endfunction

    // Configuration registers
    // Travel and dwell counts are in clock cycles; software converts from time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= sg_pkg::cfg_reset;
            move_on_reg <= sg_pkg::move_cycles_reset;
            move_off_reg <= sg_pkg::move_cycles_reset;
            dwell_reg <= sg_pkg::timer_zero;
            trip_assign_reg <= '0;
        end else if (apb_write) begin
            case (paddr)
                sg_pkg::cfg_offset: cfg_reg <= pwdata;
                sg_pkg::move_on_offset: move_on_reg <= pwdata;
                sg_pkg::move_off_offset: move_off_reg <= pwdata;
                sg_pkg::dwell_offset: dwell_reg <= pwdata;
                sg_pkg::trip_assign_offset: trip_assign_reg <= pwdata[slots-1:0];
                default: ;
            endcase
        end
    end

    // Software command pulses, one cycle
    // A pulse, not a level, so a held bus value cannot restart a move
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_close_reg <= 1'b0;
            sw_open_reg <= 1'b0;
            sw_clear_reg <= 1'b0;
        end else begin
            sw_close_reg <= apb_write && paddr == sg_pkg::command_offset && pwdata[sg_pkg::cmd_close_bit];
            sw_open_reg <= apb_write && paddr == sg_pkg::command_offset && pwdata[sg_pkg::cmd_open_bit];
            sw_clear_reg <= apb_write && paddr == sg_pkg::command_offset &&
                            pwdata[sg_pkg::cmd_clear_success_bit];
        end
    end

    // Travel and dwell sequencing; open start wins over close
    // Opening first keeps a protection open from waiting behind a close
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= sg_pkg::st_idle;
            timer_reg <= sg_pkg::timer_zero;
            dwell_dir_close_reg <= 1'b0;
            disturb_latched_reg <= 1'b0;
            last_dir_close_reg <= 1'b0;
        end else begin
            case (phase_reg)
                sg_pkg::st_idle: begin
                    if (open_start) begin
                        phase_reg <= sg_pkg::st_move_open;
                        timer_reg <= move_off_reg;
                        last_dir_close_reg <= 1'b0;
                        disturb_latched_reg <= 1'b0;
                    end else if (close_start) begin
                        phase_reg <= sg_pkg::st_move_close;
                        timer_reg <= move_on_reg;
                        last_dir_close_reg <= 1'b1;
                        disturb_latched_reg <= 1'b0;
                    end else if (single && disturb_latched_reg &&
                                 (last_dir_close_reg ? aux_closed_pos() : aux_open_pos())) begin
                        // A late end-position report from the wired contact settles a timed-out move
                        disturb_latched_reg <= 1'b0;
                    end
                end
                sg_pkg::st_move_close, sg_pkg::st_move_open: begin
                    if (arrived) begin
                        phase_reg <= sg_pkg::st_idle;
                        timer_reg <= sg_pkg::timer_zero;
                    end else if (timer_done) begin
                        // Dwell only in single-contact mode; two contacts report disturbed at once
                        if (single && move_supervised && dwell_reg != sg_pkg::timer_zero) begin
                            phase_reg <= sg_pkg::st_dwell;
                            timer_reg <= dwell_reg;
                            dwell_dir_close_reg <= (phase_reg == sg_pkg::st_move_close);
                        end else begin
                            phase_reg <= sg_pkg::st_idle;
                            timer_reg <= sg_pkg::timer_zero;
                            // An unsupervised single-contact move never ends disturbed
                            disturb_latched_reg <= move_supervised;
                        end
                    end else begin
                        timer_reg <= timer_reg - sg_pkg::timer_one;
                    end
                end
                sg_pkg::st_dwell: begin
                    if (timer_done) begin
                        phase_reg <= sg_pkg::st_idle;
                        timer_reg <= sg_pkg::timer_zero;
                        // Contact still short of the end position after the dwell: disturbed
                        disturb_latched_reg <= !(dwell_dir_close_reg ? aux_closed_pos() : aux_open_pos());
                    end else begin
                        timer_reg <= timer_reg - sg_pkg::timer_one;
                    end
                end
                // Illegal one-hot code: back to idle with the relays off
                default: begin
                    phase_reg <= sg_pkg::st_idle;
                    timer_reg <= sg_pkg::timer_zero;
                end
            endcase
        end
    end

    // Position decode, one flag per code value
    sg_pkg::position_type pos_next;
    logic timing;
    logic wired_timing;
    always_comb begin
        timing = (phase_reg != sg_pkg::st_idle);
        // Single contact: indeterminate only while the wired direction travels or dwells
        wired_timing = (phase_reg == sg_pkg::st_dwell) || (timing && move_supervised && !arrived);
        pos_next = '0;
        if (!on_wired || !off_wired) begin
            pos_next.code = sg_pkg::pos_disturb;
        end else if (aux_closed && !aux_open) begin
            pos_next.code = sg_pkg::pos_on;
        end else if (!aux_closed && aux_open) begin
            pos_next.code = sg_pkg::pos_off;
        end else begin
            // Equal contacts mean travel only while a timer runs
            pos_next.code = timing ? sg_pkg::pos_indeterm : sg_pkg::pos_disturb;
        end
        // Single contact: flags follow the supervised direction
        if (single) begin
            if (wired_timing)
                pos_next.code = sg_pkg::pos_indeterm;
            else if (disturb_latched_reg)
                pos_next.code = sg_pkg::pos_disturb;
            else if (aux_closed_pos())
                pos_next.code = sg_pkg::pos_on;
            else
                pos_next.code = sg_pkg::pos_off;
        end
        pos_next.on = (pos_next.code == sg_pkg::pos_on);
        pos_next.off = (pos_next.code == sg_pkg::pos_off);
        pos_next.indeterm = (pos_next.code == sg_pkg::pos_indeterm);
        pos_next.disturb = (pos_next.code == sg_pkg::pos_disturb);
    end

    // Single-contact flag words use the decoded code, not the pin-level code
    logic [1:0] reported_code;
    always_comb begin
        reported_code = pos_next.code;
        if (single && !on_wired && !timing && !disturb_latched_reg)
            reported_code = pos_next.code;
    end

    // Registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position <= '{on: 1'b0, off: 1'b0, indeterm: 1'b0, disturb: 1'b1, code: sg_pkg::pos_disturb};
            single_contact_mode_flag <= 1'b0;
            close_out <= 1'b0;
            open_out <= 1'b0;
            trip_out <= 1'b0;
        end else begin
            position <= pos_next;
            position.code <= reported_code;
            single_contact_mode_flag <= single;
            // Close and open relays end on new position or on timer expiry
            // Relay falls on the expiry edge itself, so it never outlasts the count
            close_out <= (phase_reg == sg_pkg::st_move_close) && !aux_closed_pos() && !timer_done;
            open_out <= (phase_reg == sg_pkg::st_move_open) && !aux_open_pos() && !timer_done;
            trip_out <= trip_next;
        end
    end

    // Success is set on feedback within travel time; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_success_flag <= 1'b0;
        end else if (arrived) begin
            command_success_flag <= 1'b1;
        end else if (close_start || open_start || sw_clear_reg) begin
            command_success_flag <= 1'b0;
        end
    end

    // APB read path, zero wait states
    // Status shows the registered flags, one cycle behind the contacts
    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[sg_pkg::st_code_lsb +: 2] = position.code;
        status_word[sg_pkg::st_on_bit] = position.on;
        status_word[sg_pkg::st_off_bit] = position.off;
        status_word[sg_pkg::st_indeterm_bit] = position.indeterm;
        status_word[sg_pkg::st_disturb_bit] = position.disturb;
        status_word[sg_pkg::st_single_bit] = single_contact_mode_flag;
        status_word[sg_pkg::st_success_bit] = command_success_flag;
        status_word[sg_pkg::st_close_out_bit] = close_out;
        status_word[sg_pkg::st_open_out_bit] = open_out;
        status_word[sg_pkg::st_trip_bit] = trip_out;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~is_known(paddr);
            prdata <= '0;
            if (psel && !penable) begin
                case (paddr)
                    sg_pkg::cfg_offset: prdata <= cfg_reg;
                    sg_pkg::move_on_offset: prdata <= move_on_reg;
                    sg_pkg::move_off_offset: prdata <= move_off_reg;
                    sg_pkg::dwell_offset: prdata <= dwell_reg;
                    sg_pkg::trip_assign_offset: prdata <= 32'(trip_assign_reg);
                    sg_pkg::status_offset: prdata <= status_word;
                    default: prdata <= '0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== pkg/sg_pkg.sv ====
// Package: constants, types and register map for the switchgear position supervisor
package sg_pkg;
    // Register byte offsets
    localparam logic [11:0] cfg_offset = 12'h000;
    localparam logic [11:0] move_on_offset = 12'h004;
    localparam logic [11:0] move_off_offset = 12'h008;
    localparam logic [11:0] dwell_offset = 12'h00c;
    localparam logic [11:0] trip_assign_offset = 12'h010;
    localparam logic [11:0] status_offset = 12'h014;
    localparam logic [11:0] command_offset = 12'h018;

    // Configuration fields
    localparam int cfg_on_wired_bit = 0;
    localparam int cfg_off_wired_bit = 1;
    localparam int cfg_trip_block_bit = 2;
    localparam logic [31:0] cfg_reset = 32'h0000_0003;

    // Command register fields, write one to start a move or clear the success flag
    localparam int cmd_close_bit = 0;
    localparam int cmd_open_bit = 1;
    localparam int cmd_clear_success_bit = 2;

    // Status field positions
    localparam int st_code_lsb = 0;
    localparam int st_on_bit = 2;
    localparam int st_off_bit = 3;
    localparam int st_indeterm_bit = 4;
    localparam int st_disturb_bit = 5;
    localparam int st_single_bit = 6;
    localparam int st_success_bit = 7;
    localparam int st_close_out_bit = 8;
    localparam int st_open_out_bit = 9;
    localparam int st_trip_bit = 10;

    localparam int timer_width = 32;
    localparam logic [timer_width-1:0] timer_zero = 32'h0000_0000;
    localparam logic [timer_width-1:0] timer_one = 32'h0000_0001;
    // Default travel time in milliseconds, converted to 40 MHz cycles
    localparam int move_time_ms = 100;
    localparam int clk_khz = 40000;
    localparam logic [timer_width-1:0] move_cycles_reset = 32'(move_time_ms * clk_khz);

    // Position codes
    localparam logic [1:0] pos_indeterm = 2'h0;
    localparam logic [1:0] pos_off = 2'h1;
    localparam logic [1:0] pos_on = 2'h2;
    localparam logic [1:0] pos_disturb = 2'h3;

    localparam int interlock_count = 3;
    localparam int trip_slots = 8;

    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_move_close = 4'h2,
        st_move_open = 4'h4,
        st_dwell = 4'h8
    } phase_type;

    typedef struct packed {
        logic on;
        logic off;
        logic indeterm;
        logic disturb;
        logic [1:0] code;
    } position_type;

    typedef struct packed {
        logic close_req;
        logic open_req;
        logic prot_open;
        logic ar_close;
        logic prot_block;
    } command_type;
endpackage

// ==== sim/sg_breaker_model.sv ====
// Behavioural switchgear whose auxiliary contacts follow the command relays
`timescale 1ns/1ps
`default_nettype none
module sg_breaker_model (
    // Clock, reset and behaviour
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] travel,
    input wire logic stuck,
    // Relays in, contacts out
    input wire logic close_out,
    input wire logic open_out,
    output logic aux_closed,
    output logic aux_open
);
    logic [7:0] cnt_reg;
    logic moving_reg;
    logic target_reg;
    logic cmd_prev_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_prev_reg <= 1'b0;
        end else begin
            cmd_prev_reg <= close_out || open_out;
        end
    end
    // Only a fresh relay edge moves it, so a relay held one cycle late is harmless
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            moving_reg <= 1'b0;
            target_reg <= 1'b0;
            aux_closed <= 1'b0;
            aux_open <= 1'b1;
        end else if (!moving_reg && (close_out || open_out) && !cmd_prev_reg) begin
            cnt_reg <= 8'h00;
            moving_reg <= 1'b1;
            target_reg <= !open_out;
            aux_closed <= 1'b0;
            aux_open <= 1'b0;
        end else if (moving_reg && !stuck && cnt_reg >= travel) begin
            moving_reg <= 1'b0;
            aux_closed <= target_reg;
            aux_open <= !target_reg;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== sim/sg_supervisor_chk.sv ====
// Port-level assertions for the switchgear position supervisor
`timescale 1ns/1ps
`default_nettype none
module sg_supervisor_chk #(
    parameter int interlocks = sg_pkg::interlock_count,
    parameter int slots = sg_pkg::trip_slots
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire sg_pkg::command_type cmd_in,
    input wire logic [interlocks-1:0] close_interlock,
    input wire logic [interlocks-1:0] open_interlock,
    input wire logic [slots-1:0] prot_trip,
    input wire logic close_out,
    input wire logic open_out,
    input wire logic trip_out,
    input wire sg_pkg::position_type position,
    input wire logic command_success_flag
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence on_held;
        position.on ##1 position.on;
    endsequence
    sequence off_held;
        position.off ##1 position.off;
    endsequence
    a_flags_onehot: assert property ($onehot({position.on, position.off, position.indeterm, position.disturb}))
        else $error("position flags not one-hot");
    a_code_agrees: assert property (position.code[1] == (position.on || position.disturb)
        && position.code[0] == (position.off || position.disturb)) else $error("code disagrees with flags");
    a_trip_cause: assert property (trip_out |-> $past(prot_trip) != '0)
        else $error("trip without any protection trip");
    a_trip_block: assert property (cmd_in.prot_block |=> !trip_out)
        else $error("trip passed a block");
    a_close_stop: assert property (on_held |-> !close_out)
        else $error("close relay held past closed position");
    a_open_stop: assert property (off_held |-> !open_out)
        else $error("open relay held past open position");
    a_close_ilock: assert property ($rose(close_out) |-> $past(close_interlock) == '0
        || $past(cmd_in.ar_close) || $past(close_interlock, 2) == '0 || $past(cmd_in.ar_close, 2))
        else $error("close issued through an interlock");
    a_open_ilock: assert property ($rose(open_out) |-> $past(open_interlock) == '0
        || $past(cmd_in.prot_open) || $past(open_interlock, 2) == '0 || $past(cmd_in.prot_open, 2))
        else $error("open issued through an interlock");
    a_success_pos: assert property ($rose(command_success_flag) |-> position.on || position.off)
        else $error("success without end position");
endmodule
bind switchgear_position_supervisor sg_supervisor_chk #(.interlocks(interlocks), .slots(slots)) chk_i (
    .pclk(pclk), .presetn(presetn), .cmd_in(cmd_in), .close_interlock(close_interlock),
    .open_interlock(open_interlock), .prot_trip(prot_trip), .close_out(close_out), .open_out(open_out),
    .trip_out(trip_out), .position(position), .command_success_flag(command_success_flag));
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the switchgear position supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, stuck;
    logic aux_closed, aux_open, close_out, open_out, trip_out, single_flag, success_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] close_interlock, open_interlock;
    logic [7:0] prot_trip, travel;
    sg_pkg::command_type cmd_in;
    sg_pkg::position_type position;
    int n_mismatch = 0;
    int n_tests = 0;
    switchgear_position_supervisor uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .aux_closed(aux_closed), .aux_open(aux_open), .cmd_in(cmd_in), .close_interlock(close_interlock),
        .open_interlock(open_interlock), .prot_trip(prot_trip), .close_out(close_out), .open_out(open_out),
        .trip_out(trip_out), .position(position), .single_contact_mode_flag(single_flag),
        .command_success_flag(success_flag));
    sg_breaker_model brk (.pclk(pclk), .presetn(presetn), .travel(travel), .stuck(stuck),
        .close_out(close_out), .open_out(open_out), .aux_closed(aux_closed), .aux_open(aux_open));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_up();
        chk(32'h1, 32'h0);
        report_and_stop();
    endtask
    // Enter right after an edge; one idle cycle follows so strobes never retoggle in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i == 20) give_up();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_code(input logic [1:0] c);
        int i;
        for (i = 0; i < 300 && position.code !== c; i++)
            @(posedge pclk);
        if (i == 300) give_up();
    endtask
    task automatic go(input logic [31:0] cfg, input logic [31:0] cmd, input logic [1:0] endc, input int mid);
        apb(1'b1, sg_pkg::cfg_offset, cfg);
        apb(1'b1, sg_pkg::command_offset, cmd);
        chk(32'(single_flag), 32'(cfg == 32'h1 || cfg == 32'h2));
        repeat (mid) @(posedge pclk);
        chk(32'(position.code), 32'(sg_pkg::pos_indeterm));
        wait_code(endc);
        chk(32'(position.code), 32'(endc));
    endtask
    task automatic t_regs();
        apb(1'b0, sg_pkg::cfg_offset, 32'h0);
        chk(rd, sg_pkg::cfg_reset);
        apb(1'b0, sg_pkg::move_off_offset, 32'h0);
        chk(rd, sg_pkg::move_cycles_reset);
        apb(1'b1, 12'h01c, 32'hffff_ffff);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h01c, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, sg_pkg::move_on_offset, 32'h14);
        apb(1'b1, sg_pkg::move_off_offset, 32'h14);
        apb(1'b1, sg_pkg::cfg_offset, 32'h0);
        @(posedge pclk);
        chk(32'(position.code), 32'(sg_pkg::pos_disturb));
    endtask
    task automatic t_two_wire();
        go(32'h3, 32'h1, sg_pkg::pos_on, 4);
        chk(32'(close_out), 32'h0);
        stuck <= 1'b1;
        go(32'h3, 32'h2, sg_pkg::pos_disturb, 8);
        chk(32'(open_out), 32'h0);
        stuck <= 1'b0;
        wait_code(sg_pkg::pos_off);
    endtask
    // Normal travel, stuck mechanism, then a late arrival covered by the dwell
    task automatic t_single(input logic [31:0] cfg, input logic [31:0] cmd, input logic [1:0] endc);
        logic [31:0] back;
        logic [1:0] home;
        back = cmd ^ 32'h3;
        home = endc ^ 2'h3;
        go(cfg, cmd, endc, 4);
        chk(32'(success_flag), 32'h1);
        chk(32'(position.indeterm), 32'h0);
        go(32'h3, back, home, 4);
        stuck <= 1'b1;
        go(cfg, cmd, sg_pkg::pos_disturb, 8);
        chk(32'(position.indeterm), 32'h0);
        stuck <= 1'b0;
        wait_code(endc);
        go(32'h3, back, home, 4);
        travel <= 8'h1e;
        apb(1'b1, sg_pkg::dwell_offset, 32'h14);
        go(cfg, cmd, endc, 26);
        travel <= 8'h05;
        apb(1'b1, sg_pkg::dwell_offset, 32'h0);
        // Unsupervised direction: relay only, no indeterminate phase, then back
        apb(1'b1, sg_pkg::command_offset, back);
        repeat (4) @(posedge pclk);
        chk(32'(position.indeterm), 32'h0);
        wait_code(home);
        go(32'h3, cmd, endc, 4);
    endtask
    task automatic t_locks();
        apb(1'b1, sg_pkg::cfg_offset, 32'h3);
        for (int i = 0; i < 3; i++) begin
            close_interlock <= 3'(1 << i);
            cmd_in.close_req <= 1'b1;
            repeat (6) @(posedge pclk);
            chk(32'(close_out), 32'h0);
            cmd_in.close_req <= 1'b0;
            @(posedge pclk);
        end
        cmd_in.ar_close <= 1'b1;
        repeat (2) @(posedge pclk);
        cmd_in.ar_close <= 1'b0;
        wait_code(sg_pkg::pos_on);
        open_interlock <= 3'b010;
        cmd_in.open_req <= 1'b1;
        cmd_in.prot_open <= 1'b1;
        cmd_in.prot_block <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(32'(open_out), 32'h0);
        cmd_in.open_req <= 1'b0;
        cmd_in.prot_block <= 1'b0;
        wait_code(sg_pkg::pos_off);
        cmd_in.prot_open <= 1'b0;
        close_interlock <= 3'b000;
        open_interlock <= 3'b000;
        @(posedge pclk);
    endtask
    task automatic t_trips();
        apb(1'b1, sg_pkg::trip_assign_offset, 32'h5a);
        for (int i = 0; i < 8; i++) begin
            prot_trip <= 8'(1 << i);
            repeat (3) @(posedge pclk);
            chk(32'(trip_out), 32'((8'h5a >> i) & 8'h01));
        end
        prot_trip <= 8'hff;
        cmd_in.prot_block <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(trip_out), 32'h0);
        cmd_in.prot_block <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(trip_out), 32'h1);
        prot_trip <= 8'h00;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, stuck} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        cmd_in = '0;
        {close_interlock, open_interlock, prot_trip} = 14'h0000;
        travel = 8'h05;
        repeat (4) @(posedge pclk);
        chk(32'(position), 32'(sg_pkg::position_type'(6'h07)));
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_two_wire();
        t_single(32'h1, 32'h1, sg_pkg::pos_on);
        t_single(32'h2, 32'h2, sg_pkg::pos_off);
        t_locks();
        t_trips();
        report_and_stop();
    end
endmodule
`default_nettype wire
